// [logic/dio_mux_pkg.sv]
// package: register map, selector codes and carrier types of the pin mux
`default_nettype none
package dio_mux_pkg;

    localparam int          ADDR_W = 8;
    localparam int          DATA_W = 32;

    localparam logic [7:0]  REG_PIN_A_DIR = 8'h00;
    localparam logic [7:0]  REG_PIN_A_SRC = 8'h04;
    localparam logic [7:0]  REG_PIN_B_DIR = 8'h08;
    localparam logic [7:0]  REG_PIN_B_SRC = 8'h0c;
    localparam logic [7:0]  REG_PIN_STATE = 8'h10;

    // pin state register fields
    localparam int          ST_LEVEL_A = 0;
    localparam int          ST_LEVEL_B = 1;
    localparam int          ST_DRIVE_A = 2;
    localparam int          ST_DRIVE_B = 3;
    localparam int          ST_KNOWN_A = 4;
    localparam int          ST_KNOWN_B = 5;

    // direction setting values
    localparam logic        DIR_OUTPUT = 1'b0;
    localparam logic        DIR_INPUT  = 1'b1;

    // constant sources
    localparam logic [31:0] CODE_CONST_ZERO = 32'h0000_0000;
    localparam logic [31:0] CODE_CONST_ONE  = 32'h0000_0001;

    // bit pointer layout: tag, bit number, group, index
    localparam logic [7:0]  PTR_TAG        = 8'h40;
    localparam int          PTR_TAG_LSB    = 24;
    localparam int          PTR_BIT_LSB    = 16;
    localparam logic [15:0] PTR_BRAKE      = 16'h0310;
    localparam logic [15:0] PTR_PRIMARY    = 16'h0601;
    localparam logic [15:0] PTR_SECONDARY  = 16'h0602;
    localparam logic [15:0] PTR_SPEED      = 16'h0603;
    localparam logic [15:0] PTR_SUPERV     = 16'h060d;

    // named selector codes; the decoder takes any bit of these words, bit 0 only for the brake command
    localparam logic [31:0] CODE_BRAKE_CMD     = 32'h4000_0310;
    localparam logic [31:0] CODE_READY         = 32'h4000_0601;
    localparam logic [31:0] CODE_ENABLED       = 32'h4001_0601;
    localparam logic [31:0] CODE_STARTED       = 32'h4002_0601;
    localparam logic [31:0] CODE_RUNNING       = 32'h4003_0601;
    localparam logic [31:0] CODE_ALARM         = 32'h4007_0601;
    localparam logic [31:0] CODE_SECOND_LOC    = 32'h4008_0601;
    localparam logic [31:0] CODE_FAULT         = 32'h400a_0601;
    localparam logic [31:0] CODE_FAULT_INV     = 32'h400c_0601;
    localparam logic [31:0] CODE_RELAY_READY   = 32'h4002_0602;
    localparam logic [31:0] CODE_RELAY_RUNNING = 32'h4003_0602;
    localparam logic [31:0] CODE_REF_RUNNING   = 32'h4004_0602;
    localparam logic [31:0] CODE_CHARGE_READY  = 32'h4009_0602;
    localparam logic [31:0] CODE_NEG_SPEED     = 32'h4000_0603;
    localparam logic [31:0] CODE_ZERO_SPEED    = 32'h4001_0603;
    localparam logic [31:0] CODE_ABOVE_LIMIT   = 32'h4002_0603;
    localparam logic [31:0] CODE_AT_SETPOINT   = 32'h4003_0603;
    localparam logic [31:0] CODE_SUPERV_1      = 32'h4000_060d;
    localparam logic [31:0] CODE_SUPERV_2      = 32'h4001_060d;
    localparam logic [31:0] CODE_SUPERV_3      = 32'h4002_060d;

    // reset: pins released, selectors on constant zero
    localparam logic        RST_DIR = DIR_INPUT;
    localparam logic [31:0] RST_SRC = CODE_CONST_ZERO;

    typedef struct packed {
        logic        brakeCmd;
        logic [15:0] primaryDriveFlags;
        logic [15:0] secondaryDriveFlags;
        logic [15:0] speedLoopFlags;
        logic [15:0] supervisionFlags;
    } drive_status_t;

    typedef struct packed {
        logic        directionSetting;
        logic [31:0] sourceSelect;
    } pin_cfg_t;

endpackage
`default_nettype wire

// [logic/dio_pin_driver.sv]
// one programmable pin: registered drive value, enable and sampled level
`timescale 1ns/1ps
`default_nettype none
module dio_pin_driver
    import dio_mux_pkg::*;
(
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic directionSetting,
    input  wire logic sourceBit,
    input  wire logic pinIn,
    output logic      pinOut,
    output logic      pinOeN,
    output logic      levelSeen
);

    // output flop: follows the source every cycle while an output
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pinOut <= 1'b0;
        end else if (directionSetting == DIR_OUTPUT) begin
            pinOut <= sourceBit;
        end else begin
            pinOut <= 1'b0;
        end
    end

    // enable is active low; released as input so field wiring may drive
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pinOeN <= 1'b1;
        end else begin
            pinOeN <= (directionSetting == DIR_INPUT);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            levelSeen <= 1'b0;
        end else begin
            levelSeen <= pinIn;
        end
    end

endmodule
`default_nettype wire

// [logic/dio_direction_source_mux.sv]
// direction and output source selection for two programmable pins
//
// What this block does
// (RULE1) pin a drives when direction setting is 0, listens when 1
// (RULE2) pin b drives when direction setting is 0, listens when 1
// (RULE3) pin a source select picks its driven signal, only while an output
// (RULE4) pin b source select picks its driven signal, only while an output
// (RULE5) brake command is selectable by its selector code
// (RULE6) primary flags bits 0,1,2,3,7,8,10,12 selectable, one code each
// (RULE7) secondary flags bits 2,3,4,9 selectable, one code each
// (RULE8) speed loop flags bits 0 to 3 selectable, one code each
// (RULE9) supervision flags bits 0 to 2 selectable, one code each
// (RULE10) a constant or general bit pointer may be selected instead
// (RULE11) output refreshed every clock; driver released while an input
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dio_direction_source_mux
    import dio_mux_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    input  wire logic          mclk,
    input  wire logic          sys_rst,
    input  wire logic [AW-1:0] regAddr,
    input  wire logic [DW-1:0] regWrData,
    input  wire logic          regWrStrobe,
    input  wire logic          regRdStrobe,
    output logic      [DW-1:0] regRdData,
    input  wire drive_status_t driveStatus,
    input  wire logic          programmablePinAIn,
    output logic               programmablePinAOut,
    output logic               programmablePinAOeN,
    input  wire logic          programmablePinBIn,
    output logic               programmablePinBOut,
    output logic               programmablePinBOeN
);

    pin_cfg_t      pinACfg_r;
    pin_cfg_t      pinBCfg_r;
    logic [DW-1:0] regRdData_r;
    logic [DW-1:0] regRdData_nxt;
    logic          srcBitA;
    logic          srcBitB;
    logic          knownA;
    logic          knownB;
    logic          levelA;
    logic          levelB;

    // true when the code is a constant or names a bit this block can point into
    function automatic logic code_known(input logic [31:0] code);
        logic [15:0] word;
        word = code[15:0];
        if (code == CODE_CONST_ZERO || code == CODE_CONST_ONE) begin
            return 1'b1;
        end
        if (code[31:PTR_TAG_LSB] != PTR_TAG) begin
            return 1'b0;
        end
        if (word == PTR_BRAKE) begin
            return code[23:PTR_BIT_LSB] == 8'h00;
        end
        if (word == PTR_PRIMARY || word == PTR_SECONDARY ||
            word == PTR_SPEED || word == PTR_SUPERV) begin
            return code[23:PTR_BIT_LSB] < 8'h10;
        end
        return 1'b0;
    endfunction

    // resolve a selector code to one status bit; unknown codes give zero
    function automatic logic pick_source(input logic [31:0]   code,
                                         input drive_status_t st);
        logic [3:0]  bitNo;
        logic [15:0] word;
        bitNo = code[PTR_BIT_LSB+3:PTR_BIT_LSB];
        word  = 16'h0000;
        if (!code_known(code)) begin
            return 1'b0;
        end
        if (code == CODE_CONST_ONE) begin // RULE10
            return 1'b1;
        end
        if (code == CODE_CONST_ZERO) begin // RULE10
            return 1'b0;
        end
        case (code[15:0])
            PTR_BRAKE:     return st.brakeCmd; // RULE5
            PTR_PRIMARY:   word = st.primaryDriveFlags; // RULE6
            PTR_SECONDARY: word = st.secondaryDriveFlags; // RULE7
            PTR_SPEED:     word = st.speedLoopFlags; // RULE8
            PTR_SUPERV:    word = st.supervisionFlags; // RULE9
            default:       word = 16'h0000;
        endcase
        // any bit of a known word is reachable, as a general pointer allows
        return word[bitNo]; // RULE10
    endfunction

    // register writes; unmapped and read-only offsets ignore writes
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pinACfg_r.directionSetting <= RST_DIR;
        end else if (regWrStrobe && regAddr == REG_PIN_A_DIR) begin
            pinACfg_r.directionSetting <= regWrData[0]; // RULE1
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pinACfg_r.sourceSelect <= RST_SRC;
        end else if (regWrStrobe && regAddr == REG_PIN_A_SRC) begin
            pinACfg_r.sourceSelect <= regWrData; // RULE3
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pinBCfg_r.directionSetting <= RST_DIR;
        end else if (regWrStrobe && regAddr == REG_PIN_B_DIR) begin
            pinBCfg_r.directionSetting <= regWrData[0]; // RULE2
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pinBCfg_r.sourceSelect <= RST_SRC;
        end else if (regWrStrobe && regAddr == REG_PIN_B_SRC) begin
            pinBCfg_r.sourceSelect <= regWrData; // RULE4
        end
    end

    assign srcBitA = pick_source(pinACfg_r.sourceSelect, driveStatus);
    assign srcBitB = pick_source(pinBCfg_r.sourceSelect, driveStatus);
    assign knownA  = code_known(pinACfg_r.sourceSelect);
    assign knownB  = code_known(pinBCfg_r.sourceSelect);

    // read data stand only in the cycle after the strobe
    always_comb begin
        regRdData_nxt = '0;
        if (regRdStrobe) begin
            if (regAddr == REG_PIN_A_DIR) begin
                regRdData_nxt[0] = pinACfg_r.directionSetting;
            end else if (regAddr == REG_PIN_A_SRC) begin
                regRdData_nxt = pinACfg_r.sourceSelect;
            end else if (regAddr == REG_PIN_B_DIR) begin
                regRdData_nxt[0] = pinBCfg_r.directionSetting;
            end else if (regAddr == REG_PIN_B_SRC) begin
                regRdData_nxt = pinBCfg_r.sourceSelect;
            end else if (regAddr == REG_PIN_STATE) begin
                regRdData_nxt[ST_LEVEL_A] = levelA;
                regRdData_nxt[ST_LEVEL_B] = levelB;
                regRdData_nxt[ST_DRIVE_A] = programmablePinAOut;
                regRdData_nxt[ST_DRIVE_B] = programmablePinBOut;
                regRdData_nxt[ST_KNOWN_A] = knownA;
                regRdData_nxt[ST_KNOWN_B] = knownB;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            regRdData_r <= '0;
        end else begin
            regRdData_r <= regRdData_nxt;
        end
    end

    assign regRdData = regRdData_r;

    // one flop stage from status to pin; no extra filtering or delay
    dio_pin_driver pinADriver (
        .mclk             (mclk),
        .sys_rst          (sys_rst),
        .directionSetting (pinACfg_r.directionSetting), // RULE1
        .sourceBit        (srcBitA), // RULE11
        .pinIn            (programmablePinAIn),
        .pinOut           (programmablePinAOut),
        .pinOeN           (programmablePinAOeN),
        .levelSeen        (levelA)
    );

    dio_pin_driver pinBDriver (
        .mclk             (mclk),
        .sys_rst          (sys_rst),
        .directionSetting (pinBCfg_r.directionSetting), // RULE2
        .sourceBit        (srcBitB), // RULE11
        .pinIn            (programmablePinBIn),
        .pinOut           (programmablePinBOut),
        .pinOeN           (programmablePinBOeN),
        .levelSeen        (levelB)
    );

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    a_pin_a_release: assert property ( // RULE1
        pinACfg_r.directionSetting == DIR_INPUT |=> programmablePinAOeN)
        else $error("pin a driven while set as input");

    a_pin_a_drive: assert property ( // RULE1
        pinACfg_r.directionSetting == DIR_OUTPUT |=> !programmablePinAOeN)
        else $error("pin a released while set as output");

    a_pin_b_dir: assert property ( // RULE2
        ##1 programmablePinBOeN == $past(pinBCfg_r.directionSetting))
        else $error("pin b enable does not follow direction");

    a_dir_write_a: assert property ( // RULE1
        regWrStrobe && regAddr == REG_PIN_A_DIR
        |=> ##1 programmablePinAOeN == $past(regWrData[0], 2))
        else $error("pin a direction write not applied in two cycles");

    a_src_a_follow: assert property ( // RULE3
        pinACfg_r.directionSetting == DIR_OUTPUT
        |=> programmablePinAOut == $past(srcBitA))
        else $error("pin a does not follow its selected source");

    a_src_a_input: assert property ( // RULE3
        pinACfg_r.directionSetting == DIR_INPUT |=> !programmablePinAOut)
        else $error("pin a source acts while set as input");

    a_src_b_follow: assert property ( // RULE4
        pinBCfg_r.directionSetting == DIR_OUTPUT
        |=> programmablePinBOut == $past(srcBitB))
        else $error("pin b does not follow its selected source");

    a_brake_source: assert property ( // RULE5
        pinACfg_r.sourceSelect == CODE_BRAKE_CMD &&
        pinACfg_r.directionSetting == DIR_OUTPUT
        |=> programmablePinAOut == $past(driveStatus.brakeCmd))
        else $error("brake command code not routed");

    a_fault_inv_src: assert property ( // RULE6
        pinBCfg_r.sourceSelect == CODE_FAULT_INV &&
        pinBCfg_r.directionSetting == DIR_OUTPUT
        |=> programmablePinBOut == $past(driveStatus.primaryDriveFlags[12]))
        else $error("primary flags bit 12 not routed");

    a_alarm_source: assert property ( // RULE6
        pinACfg_r.sourceSelect == CODE_ALARM &&
        pinACfg_r.directionSetting == DIR_OUTPUT
        |=> programmablePinAOut == $past(driveStatus.primaryDriveFlags[7]))
        else $error("primary flags bit 7 not routed");

    a_charge_source: assert property ( // RULE7
        pinACfg_r.sourceSelect == CODE_CHARGE_READY &&
        pinACfg_r.directionSetting == DIR_OUTPUT
        |=> programmablePinAOut == $past(driveStatus.secondaryDriveFlags[9]))
        else $error("secondary flags bit 9 not routed");

    a_setpoint_src: assert property ( // RULE8
        pinBCfg_r.sourceSelect == CODE_AT_SETPOINT &&
        pinBCfg_r.directionSetting == DIR_OUTPUT
        |=> programmablePinBOut == $past(driveStatus.speedLoopFlags[3]))
        else $error("speed loop bit 3 not routed");

    a_superv_source: assert property ( // RULE9
        pinACfg_r.sourceSelect == CODE_SUPERV_3 &&
        pinACfg_r.directionSetting == DIR_OUTPUT
        |=> programmablePinAOut == $past(driveStatus.supervisionFlags[2]))
        else $error("supervision bit 2 not routed");

    a_const_one: assert property ( // RULE10
        pinBCfg_r.sourceSelect == CODE_CONST_ONE &&
        pinBCfg_r.directionSetting == DIR_OUTPUT [*2]
        |=> programmablePinBOut)
        else $error("constant one not driven");

    // needs two output cycles: right after turn-on the pin still shows 0, not the old source
    a_refresh_each: assert property ( // RULE11
        pinACfg_r.directionSetting == DIR_OUTPUT && $changed(srcBitA) &&
        $past(pinACfg_r.directionSetting) == DIR_OUTPUT
        |=> $changed(programmablePinAOut))
        else $error("pin a missed a source change");

    a_read_src_a: assert property (
        regRdStrobe && regAddr == REG_PIN_A_SRC
        |=> regRdData == $past(pinACfg_r.sourceSelect))
        else $error("source select read back wrong");

    a_read_idle: assert property (
        !regRdStrobe |=> regRdData == '0)
        else $error("read data outside the answer cycle");

    a_pin_b_release: assert property ( // RULE2
        pinBCfg_r.directionSetting == DIR_INPUT |=> programmablePinBOeN)
        else $error("pin b driven while set as input");

    a_src_b_input: assert property ( // RULE4
        pinBCfg_r.directionSetting == DIR_INPUT |=> !programmablePinBOut)
        else $error("pin b source acts while set as input");

    a_dir_write_b: assert property ( // RULE2
        regWrStrobe && regAddr == REG_PIN_B_DIR
        |=> ##1 programmablePinBOeN == $past(regWrData[0], 2))
        else $error("pin b direction write not applied in two cycles");

    a_src_write_a: assert property ( // RULE3
        regWrStrobe && regAddr == REG_PIN_A_SRC
        |=> pinACfg_r.sourceSelect == $past(regWrData))
        else $error("pin a source select write not stored");

    a_const_zero: assert property ( // RULE10
        pinACfg_r.sourceSelect == CODE_CONST_ZERO &&
        pinACfg_r.directionSetting == DIR_OUTPUT
        |=> !programmablePinAOut)
        else $error("constant zero not driven");

    a_unknown_code: assert property ( // RULE10
        !knownB && pinBCfg_r.directionSetting == DIR_OUTPUT
        |=> !programmablePinBOut)
        else $error("unknown code drives pin b high");

    a_read_dir_b: assert property ( // RULE2
        regRdStrobe && regAddr == REG_PIN_B_DIR
        |=> regRdData[0] == $past(pinBCfg_r.directionSetting) && regRdData[DW-1:1] == '0)
        else $error("pin b direction read back wrong");

    a_read_level: assert property (
        regRdStrobe && regAddr == REG_PIN_STATE
        |=> regRdData[ST_LEVEL_B] == $past(levelB))
        else $error("pin b level read back wrong");

    a_neg_speed_src: assert property ( // RULE8
        pinBCfg_r.sourceSelect == CODE_NEG_SPEED &&
        pinBCfg_r.directionSetting == DIR_OUTPUT
        |=> programmablePinBOut == $past(driveStatus.speedLoopFlags[0]))
        else $error("speed loop bit 0 not routed");

    a_relay_run_src: assert property ( // RULE7
        pinACfg_r.sourceSelect == CODE_RELAY_RUNNING &&
        pinACfg_r.directionSetting == DIR_OUTPUT
        |=> programmablePinAOut == $past(driveStatus.secondaryDriveFlags[3]))
        else $error("secondary flags bit 3 not routed");

    a_brake_b_src: assert property ( // RULE5
        pinBCfg_r.sourceSelect == CODE_BRAKE_CMD &&
        pinBCfg_r.directionSetting == DIR_OUTPUT
        |=> programmablePinBOut == $past(driveStatus.brakeCmd))
        else $error("brake command code not routed to pin b");

    c_const_src: cover property (
        pinACfg_r.sourceSelect == CODE_CONST_ONE &&
        !programmablePinAOeN ##1 programmablePinAOut);

    c_brake_out: cover property (
        pinACfg_r.sourceSelect == CODE_BRAKE_CMD &&
        pinACfg_r.directionSetting == DIR_OUTPUT ##1 programmablePinAOut);

    c_turn_around: cover property (
        !programmablePinBOeN ##1 programmablePinBOeN);

    c_pointer_src: cover property (
        knownB && pinBCfg_r.sourceSelect[31:PTR_TAG_LSB] == PTR_TAG &&
        !programmablePinBOeN ##1 programmablePinBOut);

endmodule
`default_nettype wire

// [dv/dio_field_load.sv]
// field wiring model for one programmable pin, with an optional outside source
`timescale 1ns/1ps
`default_nettype none
module dio_field_load (
    input  wire logic mclk,
    input  wire logic pinOut,
    input  wire logic pinOeN,
    input  wire logic extEn,
    input  wire logic extLevel,
    output logic      pinLevel
);
    logic lastLevel = 1'b0;

    // an undriven pin toggles so a stale value never reads as a match
    always_ff @(posedge mclk) begin
        lastLevel <= pinLevel;
    end

    always_comb begin
        if (!pinOeN)
            pinLevel = pinOut;
        else if (extEn)
            pinLevel = extLevel;
        else
            pinLevel = ~lastLevel;
    end
endmodule
`default_nettype wire

// [dv/dio_direction_source_mux_tb_top.sv]
// self-checking bench for the two-pin direction and source mux
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin errors++; \
    $display("BAD t=%0t got %h exp %h", $time, got, exp); end end
module dio_direction_source_mux_tb_top import dio_mux_pkg::*;;
    logic          mclk;
    logic          sys_rst;
    logic [7:0]    regAddr;
    logic [31:0]   regWrData;
    logic          regWrStrobe;
    logic          regRdStrobe;
    logic [31:0]   regRdData;
    drive_status_t driveStatus;
    wire  [1:0]    pinIn;
    wire  [1:0]    pinOut;
    wire  [1:0]    pinOeN;
    logic [1:0]    extEn;
    logic [1:0]    extLevel;
    logic [31:0]   codes [20];
    int            errors = 0;
    int            samplesChecked = 0;
    int            cycles = 0;

    dio_direction_source_mux #(.AW(8), .DW(32)) u_dio_direction_source_mux (
        .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
        .driveStatus(driveStatus),
        .programmablePinAIn(pinIn[0]), .programmablePinAOut(pinOut[0]),
        .programmablePinAOeN(pinOeN[0]),
        .programmablePinBIn(pinIn[1]), .programmablePinBOut(pinOut[1]),
        .programmablePinBOeN(pinOeN[1]));

    dio_field_load u_field_a (.mclk(mclk), .pinOut(pinOut[0]), .pinOeN(pinOeN[0]),
        .extEn(extEn[0]), .extLevel(extLevel[0]), .pinLevel(pinIn[0]));
    dio_field_load u_field_b (.mclk(mclk), .pinOut(pinOut[1]), .pinOeN(pinOeN[1]),
        .extEn(extEn[1]), .extLevel(extLevel[1]), .pinLevel(pinIn[1]));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // the run needs under a thousand cycles; the ceiling leaves ample margin
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("BAD t=%0t timeout", $time);
            end_sim();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge mclk);
        regWrStrobe <= 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge mclk);
        regRdStrobe <= 1'b0;
        @(negedge mclk);
        `CHK(regRdData & m, e)
    endtask

    task automatic settle;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
    endtask

    // status word with only the bit that a selector code points at set
    function automatic drive_status_t oneHot(input logic [31:0] c);
        int pos;
        case (c[15:0])
            PTR_PRIMARY:   pos = 48;
            PTR_SECONDARY: pos = 32;
            PTR_SPEED:     pos = 16;
            default:       pos = 0;
        endcase
        pos = (c[15:0] == PTR_BRAKE) ? 64 : pos + int'(c[23:16]);
        return drive_status_t'(65'h1 << pos);
    endfunction

    initial begin
        regAddr = 8'h00;
        regWrData = 32'h0000_0000;
        regWrStrobe = 1'b0;
        regRdStrobe = 1'b0;
        driveStatus = '0;
        extEn = 2'b00;
        extLevel = 2'b00;
        sys_rst = 1'b1;
        codes = '{CODE_BRAKE_CMD, CODE_READY, CODE_ENABLED, CODE_STARTED, CODE_RUNNING,
            CODE_ALARM, CODE_SECOND_LOC, CODE_FAULT, CODE_FAULT_INV, CODE_RELAY_READY,
            CODE_RELAY_RUNNING, CODE_REF_RUNNING, CODE_CHARGE_READY, CODE_NEG_SPEED,
            CODE_ZERO_SPEED, CODE_ABOVE_LIMIT, CODE_AT_SETPOINT, CODE_SUPERV_1,
            CODE_SUPERV_2, CODE_SUPERV_3};
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        rdChk(REG_PIN_A_DIR, '1, 32'h1);
        rdChk(REG_PIN_B_DIR, '1, 32'h1);
        rdChk(REG_PIN_A_SRC, '1, CODE_CONST_ZERO);
        rdChk(8'h14, '1, 32'h0);
        `CHK({pinOeN, pinOut}, 4'b1100)
        $display("test reset done");

        for (int p = 0; p < 2; p++) begin
            wr(p ? REG_PIN_B_DIR : REG_PIN_A_DIR, 32'hffff_fffe);
            rdChk(p ? REG_PIN_B_DIR : REG_PIN_A_DIR, '1, 32'h0);
            for (int i = 0; i < 20; i++) begin
                wr(p ? REG_PIN_B_SRC : REG_PIN_A_SRC, codes[i]);
                driveStatus <= oneHot(codes[i]);
                settle();
                `CHK({pinOeN[p], pinOut[p], pinOeN[1-p]}, 3'b011)
                @(posedge mclk);
                driveStatus <= ~oneHot(codes[i]);
                settle();
                `CHK({pinOeN[p], pinOut[p]}, 2'b00)
            end
            wr(p ? REG_PIN_B_DIR : REG_PIN_A_DIR, 32'h1);
        end
        $display("test selector codes done");

        wr(REG_PIN_A_DIR, 32'h0);
        wr(REG_PIN_A_SRC, CODE_CONST_ONE);
        driveStatus <= '0;
        settle();
        `CHK(pinOut[0], 1'b1)
        rdChk(REG_PIN_STATE, 32'h15, 32'h15);
        wr(REG_PIN_A_SRC, CODE_CONST_ZERO);
        driveStatus <= '1;
        settle();
        `CHK(pinOut[0], 1'b0)
        wr(REG_PIN_A_SRC, 32'h4005_0601);
        driveStatus <= drive_status_t'(65'h1 << 53);
        settle();
        `CHK(pinOut[0], 1'b1)
        wr(REG_PIN_A_SRC, 32'h1234_5678);
        settle();
        rdChk(REG_PIN_STATE, 32'h14, 32'h0);
        $display("test constants and pointers done");

        wr(REG_PIN_A_SRC, CODE_BRAKE_CMD);
        driveStatus <= '1;
        wr(REG_PIN_A_DIR, 32'h1);
        extEn <= 2'b11;
        extLevel <= 2'b01;
        settle();
        `CHK({pinOeN, pinOut}, 4'b1100)
        rdChk(REG_PIN_STATE, 32'h0f, 32'h01);
        @(posedge mclk);
        extLevel <= 2'b10;
        settle();
        rdChk(REG_PIN_STATE, 32'h0f, 32'h02);
        wr(REG_PIN_STATE, '1);
        rdChk(REG_PIN_A_DIR, '1, 32'h1);
        $display("test input mode done");

        extEn <= 2'b00;
        wr(REG_PIN_A_DIR, 32'h0);
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(negedge mclk);
        `CHK({pinOeN, pinOut}, 4'b1100)
        rdChk(REG_PIN_A_SRC, '1, CODE_CONST_ZERO);
        $display("test second reset done");
        end_sim();
    end
endmodule
`undef CHK
`default_nettype wire
